//--- dv/emwq_chk.sv
// assertion checker on the work queue dma top ports
module emwq_chk (
  // clock and reset
  input wire clock,
  input wire rstn,
  // register bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // data paths
  input wire usb_byte_valid,
  input wire [7:0] usb_byte,
  input wire usb_nak,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  input wire media_req,
  input wire media_go,
  input wire [15:0] media_len,
  // status
  input wire block_done,
  input wire xfer_error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_req;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_read_wait: assert property (s_rd_req |=> s_one_wait)
    else $error("read not answered after one wait state");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_zero: assert property (s_rd_req and avs_address >= 10'h200 |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_mem_byte: assert property (mem_we |-> $past(usb_byte_valid) && mem_wdata == $past(usb_byte))
    else $error("ram write without matching byte");
  // a nak-ed byte must never reach ram, or the host would resend it twice
  chk_nak_drop: assert property (usb_byte_valid && usb_nak |=> !mem_we)
    else $error("byte written while nak");
  chk_go_req: assert property (media_go |-> $past(media_req))
    else $error("unit started without request");
  chk_go_len: assert property (media_go |-> media_len != 16'h0000 && media_len <= 16'h0200)
    else $error("unit length out of range");
  chk_go_gap: assert property (media_go |=> !media_go)
    else $error("two units back to back");
  chk_done_clean: assert property ($rose(block_done) |-> !xfer_error)
    else $error("block done with error");
  chk_done_hold: assert property (block_done && !(avs_write && !avs_waitrequest) |=> block_done)
    else $error("block done dropped without write");
endmodule

//--- dv/emwq_far.sv
// usb host byte stream and media unit model
module emwq_far (
  // clock
  input wire clock,
  // usb host side
  output logic usb_byte_valid,
  output logic [7:0] usb_byte,
  output logic usb_pkt_end,
  // media unit side
  output logic media_req
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 32'h6337;
  integer gap = 0;
  initial begin
    usb_byte_valid = 1'b0;
    usb_byte = 8'h00;
    usb_pkt_end = 1'b0;
    media_req = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // host packet, one byte per cycle
  task send_pkt(input integer n);
    integer i;
    for (i = 0; i < n; i++) begin
      @(posedge clock);
      usb_byte_valid <= 1'b1;
      usb_byte <= 8'($random(seed));
      usb_pkt_end <= (i == n - 1);
    end
    @(posedge clock);
    usb_byte_valid <= 1'b0;
    usb_pkt_end <= 1'b0;
    // idle bus shows the inverse so a stale byte cannot pass
    usb_byte <= ~usb_byte;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // media asks for units, at random promptly or slowly
  always @(posedge clock) begin
    if (gap == 0) begin
      media_req <= 1'b1;
      gap <= ($random(seed) & 1) ? 1 : 9;
    end else begin
      media_req <= 1'b0;
      gap <= gap - 1;
    end
  end
endmodule

//--- dv/emwq_top_test.sv
// self-checking bench of the work queue dma
module emwq_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, usb_byte_valid, usb_pkt_end, usb_nak, mem_we, media_req, media_go, block_done, xfer_error;
  wire [7:0] usb_byte, mem_wdata;
  wire [15:0] mem_addr, media_len;
  integer fail_count = 0, checks = 0, units = 0, rem = 0, off = 0, pn = 0, i, n;
  integer ord[3] = '{1, 0, 2};
  logic [15:0] ba[3] = '{16'h0BB8, 16'h0FA0, 16'h1388};
  logic [15:0] bl[3] = '{16'h02BC, 16'h0190, 16'h0258};
  logic on = 1'b0, cmd = 1'b0, ce = 1'b1;
  logic [15:0] qa[$], ql[$];
  logic [23:0] ea[$];
  logic [31:0] q;
  always #50 clock = ~clock;
  emwq_top dut_u (.clock(clock), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .usb_byte_valid(usb_byte_valid), .usb_byte(usb_byte),
    .usb_pkt_end(usb_pkt_end), .usb_nak(usb_nak), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .media_req(media_req), .media_go(media_go), .media_len(media_len), .block_done(block_done),
    .xfer_error(xfer_error));
  emwq_far far_u (.clock(clock), .usb_byte_valid(usb_byte_valid), .usb_byte(usb_byte),
    .usb_pkt_end(usb_pkt_end), .media_req(media_req));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // the request stands until the edge that sees waitrequest low
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) fail_count++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [9:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, 32'h00000000);
    chk(q & m, exp);
  endtask
  task wait_open;
    integer k;
    k = 0;
    while (usb_nak !== 1'b0 && k < 50) begin
      @(posedge clock);
      k++;
    end
    if (k >= 50) fail_count++;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // model: accepted bytes packed into posted buffers in queue order
  always @(posedge clock) begin
    if (usb_byte_valid === 1'b1) begin
      if (on && rem > 0 && qa.size() > 0 && !(cmd && pn >= 31)) begin
        ea.push_back({qa[0] + off[15:0], usb_byte});
        off++;
        rem--;
        if (off == ql[0] || rem == 0 || (usb_pkt_end && pn != 511)) begin
          void'(qa.pop_front());
          void'(ql.pop_front());
          off = 0;
        end
      end else if (cmd && pn >= 31) begin
        on = 1'b0;
      end
      pn = usb_pkt_end ? 0 : pn + 1;
    end
  end
  always @(posedge clock) begin
    if (mem_we === 1'b1) chk({8'h00, mem_addr, mem_wdata}, ea.size() > 0 ? {8'h00, ea.pop_front()} : 32'hFFFFFFFF);
    if (media_go === 1'b1) begin
      units++;
      chk({16'h0000, media_len}, 32'h00000200);
    end
  end
  initial begin
    #(100 * 40000);
    fail_count++;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    chk({29'h0, avs_waitrequest, usb_nak, mem_we}, 32'h00000006);
    rstn <= 1'b1;
    rd(10'h1A0, 32'h00000000);
    rd(10'h1A4, 32'h00000060);
    wr(10'h3FC, 32'hFFFFFFFF);
    rd(10'h3FC, 32'h00000000);
    wr(10'h1A0, 32'h0000000C);
    for (i = 0; i < 3; i++) begin
      wr(10'h050 + 10'(16 * i), {bl[i], ba[i]});
      wr(10'h054 + 10'(16 * i), 32'h00000200 + 32'(i));
      wr(10'h100 + 10'(8 * i), {bl[i], ba[i]});
      wr(10'h104 + 10'(8 * i), 32'h0000000A + 32'(2 * i));
    end
    wr(10'h1A8, 32'h00000600);
    wr(10'h1AC, 32'h00000600);
    for (i = 0; i < 3; i++) begin
      qa.push_back(ba[ord[i]]);
      ql.push_back(bl[ord[i]]);
      wr(10'h190, 32'(10 + 2 * ord[i]));
    end
    rem = 1536;
    on = 1'b1;
    wr(10'h1A0, 32'h00000003);
    wait_open;
    repeat (3) far_u.send_pkt(512);
    n = 0;
    while (block_done !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk(32'(units), 32'h00000003);
    chk({30'h0, xfer_error, block_done}, 32'h00000001);
    rd(10'h1A4, 32'h00000045);
    far_u.send_pkt(512);
    chk({31'h0, usb_nak}, 32'h00000001);
    // ce low freezes the bus: the clear stays pending and done stays set
    avs_address <= 10'h1A4;
    avs_writedata <= 32'h00000001;
    avs_write <= 1'b1;
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    chk({30'h0, avs_waitrequest, block_done}, 32'h00000003);
    ce <= 1'b1;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    rd(10'h1A4, 32'h00000044);
    wr(10'h1A4, 32'h0000001F);
    wr(10'h194, 32'h00000003);
    rd(10'h1A4, 32'h00000000);
    wr(10'h1A0, 32'h0000000C);
    rd(10'h1A4, 32'h00000060);
    qa.delete();
    ql.delete();
    // small command buffer, notices routed to the processor register
    wr(10'h030, 32'h001F10E1);
    wr(10'h034, 32'h00000307);
    wr(10'h1A8, 32'h00000040);
    qa.push_back(16'h10E1);
    ql.push_back(16'h001F);
    rem = 64;
    cmd = 1'b1;
    on = 1'b1;
    wr(10'h190, 32'h00000006);
    wr(10'h1A0, 32'h00000011);
    wait_open;
    far_u.send_pkt(20);
    repeat (4) @(posedge clock);
    rd(10'h1B0, 32'h80001417);
    rd(10'h1B0, 32'h00000000, 32'h80000000);
    qa.push_back(16'h10E1);
    ql.push_back(16'h001F);
    wr(10'h190, 32'h00000086);
    wait_open;
    far_u.send_pkt(40);
    repeat (4) @(posedge clock);
    chk({30'h0, usb_nak, xfer_error}, 32'h00000003);
    rd(10'h1A0, 32'h00000010);
    rd(10'h1A4, 32'h00000002, 32'h00000002);
    rd(10'h1B0, 32'h80001F17);
    chk(32'(ea.size()), 32'h00000000);
    test_done;
  end
endmodule
bind emwq_top emwq_chk chk_u (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .usb_byte_valid(usb_byte_valid), .usb_byte(usb_byte), .usb_nak(usb_nak), .mem_we(mem_we),
  .mem_wdata(mem_wdata), .media_req(media_req), .media_go(media_go), .media_len(media_len),
  .block_done(block_done), .xfer_error(xfer_error));

//--- hw/emwq_defines.vh
// register map, field positions, reset values and sizes of the work queue dma
`ifndef EMWQ_DEFINES_VH
`define EMWQ_DEFINES_VH
`define EMWQ_OFF_SRC_WQ 10'h190
`define EMWQ_OFF_SNK_WQ 10'h194
`define EMWQ_OFF_CTRL 10'h1A0
`define EMWQ_OFF_STAT 10'h1A4
`define EMWQ_OFF_SRC_CNT 10'h1A8
`define EMWQ_OFF_SNK_CNT 10'h1AC
`define EMWQ_OFF_NOTICE 10'h1B0
`define EMWQ_LUT_SRC_PAGE 3'h0
`define EMWQ_LUT_SNK_PAGE 3'h2
`define EMWQ_W1_DEST 8
`define EMWQ_W1_DIR 9
`define EMWQ_W1_LAST 10
`define EMWQ_WQ_FORCE_LAST 7
`define EMWQ_CTRL_SRC_EN 0
`define EMWQ_CTRL_SNK_EN 1
`define EMWQ_CTRL_SRC_FLUSH 2
`define EMWQ_CTRL_SNK_FLUSH 3
`define EMWQ_CTRL_CMD_MODE 4
`define EMWQ_ST_DONE 0
`define EMWQ_ST_OVERRUN 1
`define EMWQ_ST_SRC_DONE 2
`define EMWQ_ST_SNK_ERR 3
`define EMWQ_ST_OVERFLOW 4
`define EMWQ_NT_LAST 4
`define EMWQ_NT_VALID 31
`define EMWQ_CTRL_RST 5'h00
`define EMWQ_STAT_RST 5'h00
`define EMWQ_CNT_RST 32'h00000000
`define EMWQ_MTU 16'h0200
`define EMWQ_CMD_MAX 16'h001F
`define EMWQ_WQ_DEPTH 8
`endif

//--- hw/emwq_fifo.v
// work queue fifo of posted entries
module emwq_fifo #(
  parameter W = 5
) (
  // clock and reset
  input wire clock,
  input wire rstn,
  input wire ce,
  // control
  input wire flush,
  input wire push,
  input wire [W-1:0] din,
  input wire pop,
  // head and state
  output wire [W-1:0] dout,
  output wire empty,
  output wire full
);
`include "emwq_defines.vh"
  reg [W-1:0] mem [0:`EMWQ_WQ_DEPTH-1];
  reg [2:0] wp_r;
  reg [2:0] rp_r;
  reg [3:0] cnt_r;
  wire do_push;
  wire do_pop;
  // a full queue drops the push; posting past depth is a software fault
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign empty = (cnt_r == 4'h0);
  assign full = (cnt_r == 4'h8);
  assign dout = mem[rp_r];
  always @(posedge clock) begin
    if (ce && do_push) begin
      mem[wp_r] <= din;
    end
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_r <= 3'h0;
      rp_r <= 3'h0;
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (flush) begin
        wp_r <= 3'h0;
        rp_r <= 3'h0;
        cnt_r <= 4'h0;
      end else begin
        if (do_push) begin
          wp_r <= wp_r + 3'h1;
        end
        if (do_pop) begin
          rp_r <= rp_r + 3'h1;
        end
        if (do_push && !do_pop) begin
          cnt_r <= cnt_r + 4'h1;
        end else if (do_pop && !do_push) begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule

//--- hw/emwq_top.v
// endpoint to media work queue dma: source endpoint, sink media unit, register slave
// Operation
// - command mode: stop after 31 bytes, set overrun, halt, report status.
// - queue entry posted by writing lookup index to offset 0x190.
// - fulfilled buffer yields completion notice carrying request context.
// - lookup entry holds address, length, context, notice destination, last flag.
// - direction bit one means device data goes into ram.
// - source packs 512 byte packets contiguously across queued buffers.
// - filled buffer immediately sends notice with its context.
// - sink takes notice as queue entry, context indexes its table.
// - sink moves 512 byte units, releases buffer only when emptied.
// - sink sends one notice per released buffer, in order, to source.
// - source accepts sink notices as ordinary queue entries.
// - transfer ending mid buffer: notice has last flag and actual length.
// - source count exhausted: nak every packet until enabled again.
// - block done raised only after final notice has gone out.
// - short packet sets last; sink aborts and reports error if its count exceeds the bytes posted.
// - block done cleared by writing one or setting sink enable.
// - source count zero mid buffer: end, retire, notice with last.
// - sink count zero mid buffer: overflow, retire without last, stop.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
module emwq_top (
  // clock and reset
  input wire clock,
  input wire rstn,
  input wire ce,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // usb endpoint engine byte stream
  input wire usb_byte_valid,
  input wire [7:0] usb_byte,
  input wire usb_pkt_end,
  output wire usb_nak,
  // ram write port of the source
  output wire mem_we,
  output wire [15:0] mem_addr,
  output wire [7:0] mem_wdata,
  // media data unit
  input wire media_req,
  output wire media_go,
  output wire [15:0] media_len,
  // status levels
  output wire block_done,
  output wire xfer_error
);
`include "emwq_defines.vh"
////////////////////////////////////////////////////////////////////////////////
  reg [31:0] src_lut_w0 [0:15];
  reg [10:0] src_lut_w1 [0:15];
  reg [31:0] snk_lut_w0 [0:15];
  reg [10:0] snk_lut_w1 [0:15];
  reg waitrequest_r, mem_we_r, media_go_r, usb_nak_r, xfer_error_r;
  reg [31:0] readdata_r, rd_nxt;
  reg [15:0] mem_addr_r, media_len_r;
  reg [7:0] mem_wdata_r;
  reg [4:0] ctrl_r, stat_r;
  reg [31:0] src_cnt_r, snk_cnt_r, notice_r, snk_avail_r;
  reg snk_post_pend_r;
  reg [4:0] snk_post_dat_r;
  reg src_have_r, src_flast_r;
  reg [3:0] src_idx_r;
  reg [15:0] src_addr_r, src_left_r, src_fill_r, pkt_cnt_r, snk_pend_r, snk_used_r;
  wire bus_req = avs_read || avs_write;
  wire bus_wr = avs_write && !waitrequest_r;
  wire bus_rd = avs_read && !waitrequest_r;
  wire wr_src_wq = bus_wr && (avs_address == `EMWQ_OFF_SRC_WQ);
  wire wr_snk_wq = bus_wr && (avs_address == `EMWQ_OFF_SNK_WQ);
  wire wr_ctrl = bus_wr && (avs_address == `EMWQ_OFF_CTRL);
  wire wr_stat = bus_wr && (avs_address == `EMWQ_OFF_STAT);
  wire blocked = snk_post_pend_r && (avs_address == `EMWQ_OFF_SNK_WQ);
////////////////////////////////////////////////////////////////////////////////
  // queues
  wire [4:0] src_head;
  wire src_empty;
  reg src_push, src_pop, snk_push, snk_pop;
  reg [4:0] src_din;
  reg [20:0] snk_din;
  wire [20:0] snk_head;
  wire snk_empty;
  emwq_fifo #(.W(5)) u_src_wq (.clock(clock), .rstn(rstn), .ce(ce),
    .flush(wr_ctrl && avs_writedata[`EMWQ_CTRL_SRC_FLUSH]), .push(src_push), .din(src_din),
    .pop(src_pop), .dout(src_head), .empty(src_empty), .full());
  emwq_fifo #(.W(21)) u_snk_wq (.clock(clock), .rstn(rstn), .ce(ce),
    .flush(wr_ctrl && avs_writedata[`EMWQ_CTRL_SNK_FLUSH]), .push(snk_push), .din(snk_din),
    .pop(snk_pop), .dout(snk_head), .empty(snk_empty), .full());
////////////////////////////////////////////////////////////////////////////////
  // source decisions
  wire src_en = ctrl_r[`EMWQ_CTRL_SRC_EN];
  wire cmd_mode = ctrl_r[`EMWQ_CTRL_CMD_MODE];
  wire [15:0] pkt_nxt = pkt_cnt_r + {15'h0000, usb_byte_valid};
  wire byte_in = usb_byte_valid && src_en && src_have_r && (src_cnt_r != 32'h00000000);
  // overrun does not need a buffer: the 31 byte buffer is normally already retired
  wire cmd_over = usb_byte_valid && src_en && cmd_mode && (pkt_cnt_r >= `EMWQ_CMD_MAX);
  wire byte_ok = byte_in && !cmd_over;
  wire short_pkt = usb_pkt_end && (pkt_nxt != `EMWQ_MTU);
  wire cnt_end = byte_ok && (src_cnt_r == 32'h00000001);
  wire src_retire = src_have_r && ((byte_ok && (src_left_r == 16'h0001)) || cnt_end || (short_pkt && src_en));
  wire [15:0] src_len = src_fill_r + {15'h0000, byte_ok};
  wire src_last = cnt_end || short_pkt || src_flast_r || src_lut_w1[src_idx_r][`EMWQ_W1_LAST];
  wire src_to_cpu = src_lut_w1[src_idx_r][`EMWQ_W1_DEST];
  wire src_load = (!src_have_r || src_retire) && !src_empty && src_en && !cnt_end;
  // sink decisions
  wire snk_en = ctrl_r[`EMWQ_CTRL_SNK_EN];
  wire [3:0] snk_idx = snk_head[3:0];
  wire [15:0] snk_hlen = snk_head[19:4];
  wire [15:0] snk_hleft = snk_hlen - snk_used_r;
  wire snk_to_cpu = snk_lut_w1[snk_idx][`EMWQ_W1_DEST];
  wire src_cn = src_retire;
  wire snk_stall = wr_src_wq || (src_cn && src_to_cpu);
  wire snk_rel = (snk_pend_r != 16'h0000) && !snk_empty && !snk_stall && (snk_pend_r >= snk_hleft);
  wire snk_fin = snk_en && (snk_cnt_r == 32'h00000000) && (snk_pend_r == 16'h0000) && !snk_stall;
  wire snk_ovf = snk_fin && !snk_empty && (snk_used_r != 16'h0000);
  wire [15:0] unit = (snk_cnt_r < {16'h0000, `EMWQ_MTU}) ? snk_cnt_r[15:0] : `EMWQ_MTU;
  wire snk_take = media_req && snk_en && (snk_pend_r == 16'h0000) && (snk_cnt_r != 32'h00000000) &&
                  (snk_avail_r >= {16'h0000, unit});
////////////////////////////////////////////////////////////////////////////////
  // queue push and pop steering
  always @* begin
    src_push = 1'b0;
    src_din = 5'h00;
    snk_push = 1'b0;
    snk_din = 21'h000000;
    if (wr_src_wq) begin
      src_push = 1'b1;
      src_din = avs_writedata[4:0];
      src_din[4] = avs_writedata[`EMWQ_WQ_FORCE_LAST];
    end else if (snk_rel && !snk_to_cpu) begin
      src_push = 1'b1;
      src_din = {1'b0, snk_lut_w1[snk_idx][3:0]};
    end
    // source notice lands as sink entry
    if (src_cn && !src_to_cpu) begin
      snk_push = 1'b1;
      snk_din = {src_last, src_len, src_lut_w1[src_idx_r][3:0]};
    end else if (snk_post_pend_r) begin
      snk_push = 1'b1;
      snk_din = {1'b0, 16'h0000, snk_post_dat_r[3:0]};
    end
    src_pop = ce && src_load;
    snk_pop = ce && (snk_rel || snk_ovf);
  end
////////////////////////////////////////////////////////////////////////////////
  // register reads
  always @* begin
    rd_nxt = 32'h00000000;
    if (avs_address[9:7] == `EMWQ_LUT_SRC_PAGE) begin
      rd_nxt = avs_address[2] ? {21'h000000, src_lut_w1[avs_address[6:3]]} : src_lut_w0[avs_address[6:3]];
    end else if (avs_address[9:7] == `EMWQ_LUT_SNK_PAGE) begin
      rd_nxt = avs_address[2] ? {21'h000000, snk_lut_w1[avs_address[6:3]]} : snk_lut_w0[avs_address[6:3]];
    end else if (avs_address == `EMWQ_OFF_CTRL) begin
      rd_nxt = {27'h0000000, ctrl_r};
    end else if (avs_address == `EMWQ_OFF_STAT) begin
      rd_nxt = {25'h0000000, snk_empty, src_empty, stat_r};
    end else if (avs_address == `EMWQ_OFF_SRC_CNT) begin
      rd_nxt = src_cnt_r;
    end else if (avs_address == `EMWQ_OFF_SNK_CNT) begin
      rd_nxt = snk_cnt_r;
    end else if (avs_address == `EMWQ_OFF_NOTICE) begin
      rd_nxt = notice_r;
    end
  end
  // lookup tables: word 0 address and length, word 1 context, destination, direction, last
  // per entry fields
  always @(posedge clock) begin
    if (ce && bus_wr && (avs_address[9:7] == `EMWQ_LUT_SRC_PAGE)) begin
      if (avs_address[2]) begin
        src_lut_w1[avs_address[6:3]] <= avs_writedata[10:0];
      end else begin
        src_lut_w0[avs_address[6:3]] <= avs_writedata;
      end
    end
    if (ce && bus_wr && (avs_address[9:7] == `EMWQ_LUT_SNK_PAGE)) begin
      if (avs_address[2]) begin
        snk_lut_w1[avs_address[6:3]] <= avs_writedata[10:0];
      end else begin
        snk_lut_w0[avs_address[6:3]] <= avs_writedata;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // bus handshake, control and status
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h00000000;
      ctrl_r <= `EMWQ_CTRL_RST;
      stat_r <= `EMWQ_STAT_RST;
      src_cnt_r <= `EMWQ_CNT_RST;
      snk_cnt_r <= `EMWQ_CNT_RST;
      notice_r <= 32'h00000000;
      snk_post_pend_r <= 1'b0;
      snk_post_dat_r <= 5'h00;
      xfer_error_r <= 1'b0;
    end else if (ce) begin
      // one wait state; a sink post waits while the previous one is still pending
      waitrequest_r <= !(bus_req && waitrequest_r && !blocked);
      // error pin lags status by one cycle so that it comes from a flop
      xfer_error_r <= stat_r[`EMWQ_ST_OVERRUN] | stat_r[`EMWQ_ST_SNK_ERR] | stat_r[`EMWQ_ST_OVERFLOW];
      if (bus_req && waitrequest_r) begin
        readdata_r <= rd_nxt;
      end
      if (wr_snk_wq) begin
        snk_post_pend_r <= 1'b1;
        snk_post_dat_r <= avs_writedata[4:0];
      end else if (!(src_cn && !src_to_cpu)) begin
        snk_post_pend_r <= 1'b0;
      end
      if (wr_stat) begin
        stat_r <= stat_r & ~avs_writedata[4:0];
      end
      if (wr_ctrl) begin
        ctrl_r <= {avs_writedata[`EMWQ_CTRL_CMD_MODE], 2'b00, avs_writedata[1:0]};
        if (avs_writedata[`EMWQ_CTRL_SNK_EN]) begin
          stat_r[`EMWQ_ST_DONE] <= 1'b0;
        end
      end
      if (bus_wr && (avs_address == `EMWQ_OFF_SRC_CNT)) begin
        src_cnt_r <= avs_writedata;
      end else if (byte_ok) begin
        src_cnt_r <= src_cnt_r - 32'h00000001;
      end
      if (bus_wr && (avs_address == `EMWQ_OFF_SNK_CNT)) begin
        snk_cnt_r <= avs_writedata;
      end else if (snk_take) begin
        snk_cnt_r <= snk_cnt_r - {16'h0000, unit};
      end
      if (cmd_over) begin
        stat_r[`EMWQ_ST_OVERRUN] <= 1'b1;
        ctrl_r[`EMWQ_CTRL_SRC_EN] <= 1'b0;
      end
      if (cnt_end) begin
        stat_r[`EMWQ_ST_SRC_DONE] <= 1'b1;
        ctrl_r[`EMWQ_CTRL_SRC_EN] <= 1'b0;
      end
      if (snk_push && snk_din[20] && (snk_cnt_r > snk_avail_r + {16'h0000, snk_din[19:4]})) begin
        stat_r[`EMWQ_ST_SNK_ERR] <= 1'b1;
        ctrl_r[`EMWQ_CTRL_SNK_EN] <= 1'b0;
      end
      if (snk_ovf) begin
        stat_r[`EMWQ_ST_OVERFLOW] <= 1'b1;
        ctrl_r[`EMWQ_CTRL_SNK_EN] <= 1'b0;
      // done only once final notice is out
      end else if (snk_fin) begin
        stat_r[`EMWQ_ST_DONE] <= 1'b1;
        ctrl_r[`EMWQ_CTRL_SNK_EN] <= 1'b0;
      end
      // notices addressed to the processor; a read clears valid unless a new one lands
      if (bus_rd && (avs_address == `EMWQ_OFF_NOTICE)) begin
        notice_r[`EMWQ_NT_VALID] <= 1'b0;
      end
      if (src_cn && src_to_cpu) begin
        notice_r <= {1'b1, 7'h00, src_len, 3'h0, src_last, src_lut_w1[src_idx_r][3:0]};
      end else if ((snk_rel || snk_ovf) && snk_to_cpu) begin
        notice_r <= {1'b1, 7'h00, snk_hlen, 4'h0, snk_lut_w1[snk_idx][3:0]};
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // source endpoint filling buffers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src_have_r <= 1'b0;
      src_flast_r <= 1'b0;
      src_idx_r <= 4'h0;
      src_addr_r <= 16'h0000;
      src_left_r <= 16'h0000;
      src_fill_r <= 16'h0000;
      pkt_cnt_r <= 16'h0000;
      mem_we_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 8'h00;
      usb_nak_r <= 1'b1;
    end else if (ce) begin
      pkt_cnt_r <= usb_pkt_end ? 16'h0000 : pkt_nxt;
      mem_we_r <= byte_ok && src_lut_w1[src_idx_r][`EMWQ_W1_DIR];
      mem_addr_r <= src_addr_r;
      mem_wdata_r <= usb_byte;
      // nak while disabled or out of buffers
      usb_nak_r <= !(src_en && (src_have_r || !src_empty) && (src_cnt_r != 32'h00000000));
      // contiguous packing, overrun continues in next buffer
      if (byte_ok) begin
        src_addr_r <= src_addr_r + 16'h0001;
        src_left_r <= src_left_r - 16'h0001;
        src_fill_r <= src_len;
      end
      // retire on fill, count end sets last
      if (src_retire) begin
        src_have_r <= 1'b0;
      end
      if (src_load) begin
        src_have_r <= 1'b1;
        src_idx_r <= src_head[3:0];
        src_flast_r <= src_head[4];
        src_addr_r <= src_lut_w0[src_head[3:0]][15:0];
        src_left_r <= src_lut_w0[src_head[3:0]][31:16];
        src_fill_r <= 16'h0000;
      end
      if (wr_ctrl && avs_writedata[`EMWQ_CTRL_SRC_FLUSH]) begin
        src_have_r <= 1'b0;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // sink media unit draining buffers
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      snk_avail_r <= 32'h00000000;
      snk_pend_r <= 16'h0000;
      snk_used_r <= 16'h0000;
      media_go_r <= 1'b0;
      media_len_r <= 16'h0000;
    end else if (ce) begin
      media_go_r <= snk_take;
      // units of 512, buffer held while bytes remain
      if (snk_take) begin
        media_len_r <= unit;
        snk_pend_r <= unit;
      end else if (snk_rel) begin
        snk_pend_r <= snk_pend_r - snk_hleft;
      end else if ((snk_pend_r != 16'h0000) && !snk_empty && !snk_stall) begin
        snk_used_r <= snk_used_r + snk_pend_r;
        snk_pend_r <= 16'h0000;
      end
      // one release per cycle, in queue order
      if (snk_rel || snk_ovf) begin
        snk_used_r <= 16'h0000;
      end
      snk_avail_r <= snk_avail_r + (snk_push ? {16'h0000, snk_din[19:4]} : 32'h00000000) -
                     (snk_take ? {16'h0000, unit} : 32'h00000000);
      if (wr_ctrl && avs_writedata[`EMWQ_CTRL_SNK_FLUSH]) begin
        snk_avail_r <= 32'h00000000;
        snk_pend_r <= 16'h0000;
        snk_used_r <= 16'h0000;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata = readdata_r;
  assign usb_nak = usb_nak_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign media_go = media_go_r;
  assign media_len = media_len_r;
  assign block_done = stat_r[`EMWQ_ST_DONE];
  assign xfer_error = xfer_error_r;
endmodule
